// File: eclv_map.vh
// Summary of operation
// RL1: during an alarm the analog output shows an error level, not temperature
// RL2: thirteen distinct output levels, one per error class
// RL3: calibration or configuration errors alternate at 1 Hz with full scale
// RL4: start during an alternating warning freezes the output level
// RL5: start during a warning escalates it to a fault, lamp and relay on
// RL6: an alarm stays latched until power is cycled
// RL7: far side ignores levels while the device powers down
// RL8: far side decodes with a tolerance window per level
// RL9: the full error code is kept and offered to the diagnostic port
// RL10: error 101 gives the first level as a continuous fault
// RL11: error 102 gives the second level, 1.33 V
// RL12: error 103 gives the third level, 2.00 V
// RL13: errors 107, 108, 307 to 310 give the fourth level, 2.66 V
// RL14: errors 201 to 203 give the fifth level, 3.33 V
// RL15: error 304 gives the sixth level, 4.00 V
// RL16: errors 9xx give the seventh level, 4.66 V
// RL17: the alternation uses equal half periods from the system clock
`ifndef ECLV_MAP_VH
`define ECLV_MAP_VH
`define ECLV_CLK_HZ        10000000
`define ECLV_TOGGLE_HZ     1
// half of one 1 Hz period at the system clock, sized for the divider
`define ECLV_HALF_CYC      25'h04C4B40
`define ECLV_DAC_W         10
`define ECLV_CODE_W        10
`define ECLV_LVL_W         4
// dac codes in 10 mV units, 10 V full scale
`define ECLV_DAC_FULL      10'h3E8
`define ECLV_LVL_NONE      4'h0
`define ECLV_LVL_FULL      4'hD
`define ECLV_CODE_NONE     10'h000
`endif

// File: eclv_level_map.v
`default_nettype none
`include "eclv_map.vh"
module eclv_level_map (
    input  wire [`ECLV_CODE_W-1:0] code,
    output reg  [`ECLV_LVL_W-1:0]  level,
    output reg  [`ECLV_DAC_W-1:0]  dac,
    output reg                     toggling
);
    always @* begin
        level    = `ECLV_LVL_NONE;
        toggling = 1'b0;
        case (code)
            10'h065: level = 4'h1; // RL10
            10'h066: level = 4'h2; // RL11
            10'h067: level = 4'h3; // RL12
            10'h06B, 10'h06C, 10'h133, 10'h134,
            10'h135, 10'h136: level = 4'h4; // RL13
            10'h0C9, 10'h0CA, 10'h0CB: level = 4'h5; // RL14
            10'h130: level = 4'h6; // RL15
            10'h068: begin
                level    = 4'h8;
                toggling = 1'b1; // RL3
            end
            10'h069, 10'h06F, 10'h070, 10'h071, 10'h072: begin
                level    = 4'h9;
                toggling = 1'b1; // RL3
            end
            10'h06A: begin
                level    = 4'h9;
                toggling = 1'b1; // RL3
            end
            10'h12E: begin
                level    = 4'hA;
                toggling = 1'b1; // RL3
            end
            10'h12F: begin
                level    = 4'hB;
                toggling = 1'b1; // RL3
            end
            10'h0D3: begin
                level    = 4'hC;
                toggling = 1'b1; // RL3
            end
            default: begin
                if (code >= 10'h384 && code <= 10'h3E7)
                    level = 4'h7; // RL16
            end
        endcase
    end
    // RL2: twelve steps of 10 V / 15 plus full scale, codes in 10 mV units
    always @* begin
        case (level)
            4'h1:    dac = 10'h042;
            4'h2:    dac = 10'h085;
            4'h3:    dac = 10'h0C8;
            4'h4:    dac = 10'h10A;
            4'h5:    dac = 10'h14D;
            4'h6:    dac = 10'h190;
            4'h7:    dac = 10'h1D2;
            4'h8:    dac = 10'h215;
            4'h9:    dac = 10'h258;
            4'hA:    dac = 10'h29A;
            4'hB:    dac = 10'h2DD;
            4'hC:    dac = 10'h320;
            4'hD:    dac = `ECLV_DAC_FULL;
            default: dac = 10'h000;
        endcase
    end
endmodule
`default_nettype wire

// File: eclv_encoder.v
`default_nettype none
`include "eclv_map.vh"
module eclv_encoder #(
    parameter [24:0] HALF = `ECLV_HALF_CYC
) (
    input  wire                    clk,
    input  wire                    nrst,
    input  wire [`ECLV_CODE_W-1:0] err_code,
    input  wire                    err_valid,
    input  wire [`ECLV_DAC_W-1:0]  temp_value,
    input  wire                    start_pin,
    output reg  [`ECLV_DAC_W-1:0]  dac_out,
    output reg  [`ECLV_CODE_W-1:0] diag_code,
    output reg  [`ECLV_LVL_W-1:0]  diag_level,
    output reg                     alarm_active,
    output reg                     alarm_fault,
    output reg                     alarm_relay
);
    localparam [1:0] ST_IDLE  = 2'b01;
    localparam [1:0] ST_ALARM = 2'b10;

    reg [2:0]                 start_sync;
    reg                       start_level;
    reg [1:0]                 state;
    reg [`ECLV_CODE_W-1:0]    held_code;
    reg                       escalated;
    reg [24:0]                half_cnt;
    reg                       phase_hi;
    wire [`ECLV_LVL_W-1:0]    map_level;
    wire [`ECLV_DAC_W-1:0]    map_dac;
    wire                      map_toggle;

    eclv_level_map u_map (
        .code     (held_code),
        .level    (map_level),
        .dac      (map_dac),
        .toggling (map_toggle)
    );

    // start pin synchroniser, change accepted when stages 2 and 3 agree
    always @(posedge clk) begin
        if (!nrst) begin
            start_sync  <= 3'b000;
            start_level <= 1'b0;
        end else begin
            start_sync <= {start_sync[1:0], start_pin};
            if (start_sync[1] == start_sync[2])
                start_level <= start_sync[2];
        end
    end

    // latch first alarm until power cycle (nrst)
    always @(posedge clk) begin
        if (!nrst) begin
            state     <= ST_IDLE;
            held_code <= `ECLV_CODE_NONE;
            escalated <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (err_valid && err_code != `ECLV_CODE_NONE) begin
                        held_code <= err_code; // RL9
                        state     <= ST_ALARM; // RL6
                    end
                end
                ST_ALARM: begin
                    if (map_toggle && start_level)
                        escalated <= 1'b1; // RL5
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // 1 Hz alternation, equal half periods
    always @(posedge clk) begin
        if (!nrst || state != ST_ALARM || escalated) begin
            half_cnt <= 25'h0000000;
            phase_hi <= 1'b0;
        end else if (half_cnt == HALF - 25'h0000001) begin
            half_cnt <= 25'h0000000;
            phase_hi <= ~phase_hi; // RL17
        end else begin
            half_cnt <= half_cnt + 25'h0000001;
        end
    end

    always @(posedge clk) begin
        if (!nrst) begin
            dac_out      <= 10'h000;
            diag_code    <= `ECLV_CODE_NONE;
            diag_level   <= `ECLV_LVL_NONE;
            alarm_active <= 1'b0;
            alarm_fault  <= 1'b0;
            alarm_relay  <= 1'b0;
        end else if (state == ST_ALARM) begin
            diag_code    <= held_code; // RL9
            diag_level   <= map_level;
            alarm_active <= 1'b1;
            alarm_fault  <= !map_toggle || escalated; // RL5
            alarm_relay  <= !map_toggle || escalated;
            if (map_toggle && !escalated && phase_hi)
                dac_out <= `ECLV_DAC_FULL; // RL3
            else
                dac_out <= map_dac; // RL1 RL4
        end else begin
            dac_out <= temp_value;
        end
    end
endmodule
`default_nettype wire

// File: eclv_plc_model.sv
`default_nettype none
module eclv_plc_model (
    input  wire logic       clk,
    input  wire logic       powered,
    input  wire logic [9:0] volts,
    output var  logic [3:0] level
);
    timeunit 1ns;
    timeprecision 1ns;
    int n;
    always @(posedge clk) begin
        level <= 4'h0;
        if (powered)
            for (n = 1; n < 16; n++)
                if (volts + 16 > n * 200 / 3 && volts < n * 200 / 3 + 16)
                    level <= n[3:0];
    end
endmodule
`default_nettype wire

// File: eclv_checker.sv
`default_nettype none
module eclv_checker (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       err_valid,
    input wire logic       start_pin,
    input wire logic [9:0] err_code,
    input wire logic [9:0] dac_out,
    input wire logic [9:0] diag_code,
    input wire logic       alarm_active,
    input wire logic       alarm_fault,
    input wire logic       alarm_relay
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_alarm_kept: assert property (alarm_active |=> alarm_active)
        else $error("alarm dropped");
    a_code_kept: assert property (alarm_active |=> $stable(diag_code))
        else $error("code changed");
    a_take_delay: assert property ($rose(alarm_active) |->
        $past(err_valid, 2) && $past(err_code, 2) != 10'h000)
        else $error("alarm without error");
    a_relay_fault: assert property (alarm_fault |-> alarm_relay)
        else $error("relay open in fault");
    a_start_fault: assert property ((alarm_active && start_pin) [*6] |=>
        alarm_fault && alarm_relay) else $error("start not escalated");
    a_fault_frozen: assert property (alarm_fault &&
        $past(alarm_fault, 2) |-> $stable(dac_out)) else $error("not held");
    a_lvl_first: assert property (alarm_active &&
        diag_code == 10'h065 |-> dac_out == 10'h042 && alarm_fault)
        else $error("level one wrong");
    a_lvl_second: assert property (alarm_active &&
        diag_code == 10'h066 |-> dac_out == 10'h085) else $error("level two");
    a_lvl_sixth: assert property (alarm_active &&
        diag_code == 10'h130 |-> dac_out == 10'h190) else $error("level six");
    a_toggle_pair: assert property (alarm_active &&
        diag_code == 10'h068 |-> dac_out inside {10'h215, 10'h3E8})
        else $error("toggle value wrong");
endmodule
bind eclv_encoder eclv_checker chk (.clk, .nrst, .err_valid, .start_pin,
    .err_code,
    .dac_out, .diag_code, .alarm_active, .alarm_fault, .alarm_relay);
`default_nettype wire

// File: test_error_code_level_encoder.sv
`default_nettype none
module test_error_code_level_encoder;
    timeunit 1ns;
    timeprecision 1ns;
    logic            clk = 0, nrst = 0, err_valid = 0, start_pin = 0;
    logic      [9:0] err_code = 0, temp_value = 0, e;
    wire logic [9:0] dac_out, diag_code;
    wire logic [3:0] diag_level, plc_level;
    wire logic       alarm_active, alarm_fault, alarm_relay;
    int              bad_count = 0, checks_done = 0, seed = 65, i, k;
    localparam int   HALF_SIM = 50;
    logic      [9:0] cl [26] = '{10'h065, 10'h066, 10'h067, 10'h06B, 10'h06C,
        10'h133, 10'h134, 10'h135, 10'h136, 10'h0C9, 10'h0CA, 10'h0CB,
        10'h130, 10'h385, 10'h391, 10'h395, 10'h068, 10'h069, 10'h06A,
        10'h06F, 10'h070, 10'h071, 10'h072, 10'h12E, 10'h12F, 10'h0D3};
    eclv_encoder #(.HALF(25'(HALF_SIM))) uut (.clk, .nrst, .err_code,
        .err_valid, .temp_value,
        .start_pin, .dac_out, .diag_code, .diag_level, .alarm_active,
        .alarm_fault, .alarm_relay);
    eclv_plc_model plc (.clk, .powered(nrst), .volts(dac_out),
        .level(plc_level));
    initial forever #50 clk = ~clk;
    function automatic logic [3:0] lvl(input logic [9:0] c);
        case (c)
            10'h065: return 4'h1;
            10'h066: return 4'h2;
            10'h067: return 4'h3;
            10'h06B, 10'h06C, 10'h133, 10'h134, 10'h135, 10'h136: return 4'h4;
            10'h0C9, 10'h0CA, 10'h0CB: return 4'h5;
            10'h130: return 4'h6;
            10'h068: return 4'h8;
            10'h069, 10'h06A, 10'h06F, 10'h070, 10'h071, 10'h072: return 4'h9;
            10'h12E: return 4'hA;
            10'h12F: return 4'hB;
            10'h0D3: return 4'hC;
            default: return 4'h7;
        endcase
    endfunction
    task chk(input string nm, input logic [9:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask
    task conclude;
        if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task run(input logic [9:0] c);
        nrst = 0;
        tick(8);
        chk("off", plc_level, 0);
        chk("clear", alarm_active, 0);
        nrst = 1;
        temp_value = $random(seed);
        tick(4);
        chk("temp", dac_out, temp_value);
        err_code = c;
        err_valid = 1;
        tick(1);
        err_valid = 0;
        for (k = 0; k < 8 && alarm_active !== 1'b1; k++) tick(1);
        if (k == 8) begin
            chk("alarm", alarm_active, 1);
            conclude;
        end
        tick(2);
        chk("dac", dac_out, 10'(lvl(c) * 200 / 3));
        chk("level", diag_level, lvl(c));
        chk("plc", plc_level, lvl(c));
        chk("fault", alarm_fault, lvl(c) < 4'h8);
        if (lvl(c) > 4'h7) begin
            for (k = 0; k < 200 && dac_out !== 10'h3E8; k++) tick(1);
            chk("full", dac_out, 10'h3E8);
            if (k == 200) conclude;
            for (k = 0; k < 200 && dac_out === 10'h3E8; k++) tick(1);
            chk("half", k, HALF_SIM);
            if (k == 200) conclude;
            chk("back", dac_out, 10'(lvl(c) * 200 / 3));
        end
        err_code = $random(seed);
        err_valid = 1;
        tick(1);
        err_valid = 0;
        tick(4);
        chk("code", diag_code, c);
        start_pin = 1;
        tick(8);
        chk("relay", alarm_relay, 1);
        chk("held", dac_out, 10'(lvl(c) * 200 / 3));
        tick(60);
        chk("frozen", dac_out, 10'(lvl(c) * 200 / 3));
        start_pin = 0;
        tick(2);
        chk("latched", alarm_active, 1);
    endtask
    initial begin
        tick(1);
        for (i = 0; i < 26; i++) run(cl[i]);
        for (i = 0; i < 6; i++) begin
            e = cl[$unsigned($random(seed)) % 26];
            run(e);
        end
        conclude;
    end
endmodule
`default_nettype wire
